//--- core/pmxc_cfg.svh
// constants for the MAC-side extended control register
`ifndef PMXC_CFG_SVH
`define PMXC_CFG_SVH
`define PMXC_ADDR_W        5
`define PMXC_DATA_W        16
`define PMXC_OFF_CTRL      5'h17
`define PMXC_OFF_STATUS    5'h18
`define PMXC_MODE_HI       15
`define PMXC_MODE_LO       12
`define PMXC_IOV_HI        11
`define PMXC_IOV_LO        9
`define PMXC_SKEW_BIT      8
`define PMXC_WRAP_BIT      7
`define PMXC_REV_BIT       6
`define PMXC_LPI_BIT       5
`define PMXC_TXREV_BIT     1
`define PMXC_WR_MASK       16'hFFE2
`define PMXC_RESET_VAL     16'h0000
`define PMXC_MODE_GMII     4'h0
`define PMXC_MODE_RGMII    4'h1
`define PMXC_MODE_TBI      4'h2
`define PMXC_MODE_RTBI     4'h3
`define PMXC_IOV_3V3       3'h0
`define PMXC_IOV_2V5       3'h1
`define PMXC_ZERO_WORD     16'h0000
`define PMXC_ST_ACT_BIT    3
`define PMXC_ST_TBI_BIT    2
`define PMXC_ST_WRAP_BIT   1
`define PMXC_ST_LPI_BIT    0
`define PMXC_SYNC_MID      1
`define PMXC_SYNC_LAST     2
`define PMXC_SYNC_RESET    3'h0
`endif

//--- core/pmxc_pkg.sv
// types for the MAC-side extended control register
package pmxc_pkg;
  typedef enum logic [2:0] {PMXC_IF_GMII, PMXC_IF_RGMII, PMXC_IF_TBI, PMXC_IF_RTBI, PMXC_IF_RSVD} pmxc_if_e;
  typedef struct packed {
    logic [15:0] ctrl_reg;
    logic [15:0] rdata_reg;
    logic [2:0]  act_sync_reg;
  } pmxc_state_s;
  typedef struct packed {
    logic [7:0] txd_reg;
  } pmxc_txmap_s;
endpackage

//--- core/pmxc_top.sv
// MAC-side extended control register with its mode decode
// Function
// - reset selects code 0000, GMII/MII
// - I/O level 000=3.3V, 001=2.5V, reset 000
// - skew compensation follows its enable, resets off
// - TBI wrap only when enabled and TBI
// - TBI bit reversal only in TBI mode
// - network activity clears low-power idle enable
// - transmit data bits reversed when bit set
// - reserved bits read as zero
//
// Strobed register access is this design's own decision.
`timescale 1ns/100ps
`include "pmxc_cfg.svh"
module pmxc_top
  import pmxc_pkg::*;
#(
  parameter int TXD_W = 8
) (
  input  wire logic                      CLK,
  input  wire logic                      RST,
  input  wire logic [`PMXC_ADDR_W-1:0]   ADDR,
  input  wire logic [`PMXC_DATA_W-1:0]   WDATA,
  input  wire logic                      WR,
  input  wire logic                      RD,
  output logic      [`PMXC_DATA_W-1:0]   RDATA,
  input  wire logic                      NET_ACTIVITY,
  input  wire logic [TXD_W-1:0]          MAC_TXD,
  output logic      [TXD_W-1:0]          PCS_TXD,
  output logic                           IF_GMII,
  output logic                           IF_RGMII,
  output logic                           IF_TBI,
  output logic                           IF_RTBI,
  output logic                           IO_2V5,
  output logic                           RGMII_SKEW_EN,
  output logic                           TBI_WRAP_TO_MAC,
  output logic                           TBI_BIT_REVERSE,
  output logic                           LOW_POWER_IDLE
);
  // ==========================================================
  // state
  pmxc_state_s             st_reg;
  pmxc_state_s             st_next;

  // ==========================================================
  // decoded views of the registered state and of the bus write inputs
  pmxc_if_e                if_mode;
  logic                    activity;
  logic                    sync_mid;
  logic                    sync_last;
  logic                    wr_ctrl;
  logic [3:0]              mode_code;
  logic [2:0]              iov_code;
  logic                    skew_bit;
  logic                    wrap_bit;
  logic                    rev_bit;
  logic                    lpi_bit;
  logic                    txrev_bit;
  logic                    is_gmii;
  logic                    is_rgmii;
  logic                    is_tbi;
  logic                    is_rtbi;
  logic [`PMXC_DATA_W-1:0] ctrl_view;
  logic [`PMXC_DATA_W-1:0] status_view;
  logic [`PMXC_DATA_W-1:0] wr_word;

  // ==========================================================
  // field helpers
  function automatic pmxc_if_e decode_mode(input logic [3:0] code);
    unique case (code)
      `PMXC_MODE_GMII:  decode_mode = PMXC_IF_GMII;
      `PMXC_MODE_RGMII: decode_mode = PMXC_IF_RGMII;
      `PMXC_MODE_TBI:   decode_mode = PMXC_IF_TBI;
      `PMXC_MODE_RTBI:  decode_mode = PMXC_IF_RTBI;
      default:          decode_mode = PMXC_IF_RSVD;
    endcase
  endfunction

  function automatic logic [3:0] get_mode(input logic [`PMXC_DATA_W-1:0] word);
    get_mode = word[`PMXC_MODE_HI:`PMXC_MODE_LO];
  endfunction

  function automatic logic [2:0] get_iov(input logic [`PMXC_DATA_W-1:0] word);
    get_iov = word[`PMXC_IOV_HI:`PMXC_IOV_LO];
  endfunction

  // reserved bits never reach the register or the bus
  function automatic logic [`PMXC_DATA_W-1:0] keep_writable(input logic [`PMXC_DATA_W-1:0] word);
    keep_writable = word & `PMXC_WR_MASK;
  endfunction

  function automatic logic addr_hit(
    input logic [`PMXC_ADDR_W-1:0] a,
    input logic [`PMXC_ADDR_W-1:0] off
  );
    addr_hit = (a == off);
  endfunction

  function automatic logic [`PMXC_DATA_W-1:0] status_word(
    input logic act,
    input logic tbi,
    input logic wrap,
    input logic lpi
  );
    status_word                    = `PMXC_ZERO_WORD;
    status_word[`PMXC_ST_ACT_BIT]  = act;
    status_word[`PMXC_ST_TBI_BIT]  = tbi;
    status_word[`PMXC_ST_WRAP_BIT] = wrap;
    status_word[`PMXC_ST_LPI_BIT]  = lpi;
  endfunction

  // activity wins over a write that sets the low-power bit
  function automatic logic [`PMXC_DATA_W-1:0] next_ctrl(
    input logic [`PMXC_DATA_W-1:0] cur,
    input logic                    wr_hit,
    input logic [`PMXC_DATA_W-1:0] wr_val,
    input logic                    act
  );
    next_ctrl = wr_hit ? wr_val : cur;
    if (act) begin
      next_ctrl[`PMXC_LPI_BIT] = 1'b0;
    end
  endfunction

  // unmapped addresses read as zero
  function automatic logic [`PMXC_DATA_W-1:0] read_mux(
    input logic [`PMXC_ADDR_W-1:0] a,
    input logic [`PMXC_DATA_W-1:0] ctrl,
    input logic [`PMXC_DATA_W-1:0] status
  );
    unique case (a)
      `PMXC_OFF_CTRL:   read_mux = ctrl;
      `PMXC_OFF_STATUS: read_mux = status;
      default:          read_mux = `PMXC_ZERO_WORD;
    endcase
  endfunction

  // ==========================================================
  // field extraction
  assign mode_code = get_mode(st_reg.ctrl_reg);
  assign iov_code  = get_iov(st_reg.ctrl_reg);
  assign skew_bit  = st_reg.ctrl_reg[`PMXC_SKEW_BIT];
  assign wrap_bit  = st_reg.ctrl_reg[`PMXC_WRAP_BIT];
  assign rev_bit   = st_reg.ctrl_reg[`PMXC_REV_BIT];
  assign lpi_bit   = st_reg.ctrl_reg[`PMXC_LPI_BIT];
  assign txrev_bit = st_reg.ctrl_reg[`PMXC_TXREV_BIT];
  assign if_mode   = decode_mode(mode_code);
  assign is_gmii   = (if_mode == PMXC_IF_GMII);
  assign is_rgmii  = (if_mode == PMXC_IF_RGMII);
  assign is_tbi    = (if_mode == PMXC_IF_TBI);
  assign is_rtbi   = (if_mode == PMXC_IF_RTBI);

  // ==========================================================
  // activity synchroniser
  // activity is high only while the second and third stage are both high
  assign sync_mid  = st_reg.act_sync_reg[`PMXC_SYNC_MID];
  assign sync_last = st_reg.act_sync_reg[`PMXC_SYNC_LAST];
  assign activity  = sync_mid & sync_last;

  // ==========================================================
  // bus decode
  assign wr_ctrl     = WR & addr_hit(ADDR, `PMXC_OFF_CTRL);
  assign wr_word     = keep_writable(WDATA);
  assign ctrl_view   = keep_writable(st_reg.ctrl_reg);
  assign status_view = status_word(activity, is_tbi, wrap_bit & is_tbi, lpi_bit);

  // ==========================================================
  // next state
  always_comb begin
    st_next              = st_reg;
    st_next.act_sync_reg = {st_reg.act_sync_reg[`PMXC_SYNC_MID:0], NET_ACTIVITY};
    st_next.ctrl_reg     = next_ctrl(st_reg.ctrl_reg, wr_ctrl, wr_word, activity);
    st_next.rdata_reg    = `PMXC_ZERO_WORD;
    if (RD) begin
      st_next.rdata_reg = read_mux(ADDR, ctrl_view, status_view);
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st_reg <= '{
        ctrl_reg:     `PMXC_RESET_VAL,
        rdata_reg:    `PMXC_ZERO_WORD,
        act_sync_reg: `PMXC_SYNC_RESET
      };
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // control outputs
  assign RDATA           = st_reg.rdata_reg;
  assign IF_GMII         = is_gmii;
  assign IF_RGMII        = is_rgmii;
  assign IF_TBI          = is_tbi;
  assign IF_RTBI         = is_rtbi;
  assign IO_2V5          = (iov_code == `PMXC_IOV_2V5);
  assign RGMII_SKEW_EN   = skew_bit;
  assign TBI_WRAP_TO_MAC = wrap_bit & is_tbi;
  assign TBI_BIT_REVERSE = rev_bit & is_tbi;
  assign LOW_POWER_IDLE  = lpi_bit;

  // ==========================================================
  // transmit pin order
  pmxc_txmap #(
    .W(TXD_W)
  ) u_txmap (
    .clk     (CLK),
    .rst     (RST),
    .reverse (txrev_bit),
    .din     (MAC_TXD),
    .dout    (PCS_TXD)
  );
endmodule // pmxc_top

//--- core/pmxc_txmap.sv
// transmit data pin order mapper
`timescale 1ns/100ps
`include "pmxc_cfg.svh"
module pmxc_txmap
  import pmxc_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         reverse,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  pmxc_txmap_s st_reg;
  pmxc_txmap_s st_next;

  always_comb begin
    st_next = st_reg;
    for (int i = 0; i < W; i++) begin
      st_next.txd_reg[i] = reverse ? din[W-1-i] : din[i];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign dout = st_reg.txd_reg;
endmodule // pmxc_txmap

//--- tb/pmxc_checker.sv
// concurrent checks on the extended control register ports
`timescale 1ns/100ps
module pmxc_checker (
  input wire logic        CLK,
  input wire logic        RST,
  input wire logic [4:0]  ADDR,
  input wire logic [15:0] WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [15:0] RDATA,
  input wire logic        NET_ACTIVITY,
  input wire logic        IF_GMII,
  input wire logic        IF_TBI,
  input wire logic        RGMII_SKEW_EN,
  input wire logic        TBI_WRAP_TO_MAC,
  input wire logic        LOW_POWER_IDLE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  logic wc;
  assign wc = WR && ADDR == 5'h17;
  sequence s_wr_rd;
    wc ##1 (RD && !WR && ADDR == 5'h17);
  endsequence
  a_mode_tbi: assert property (wc |=> IF_TBI == ($past(WDATA[15:12]) == 4'h2))
    else $error("tbi select wrong");
  a_mode_gmii: assert property (wc |=> IF_GMII == ($past(WDATA[15:12]) == 4'h0))
    else $error("gmii select wrong");
  a_skew_en: assert property (wc |=> RGMII_SKEW_EN == $past(WDATA[8]))
    else $error("skew enable wrong");
  a_wrap_tbi: assert property (wc |=> TBI_WRAP_TO_MAC == ($past(WDATA[7]) && $past(WDATA[15:12]) == 4'h2))
    else $error("wrap enable wrong");
  a_rsvd_zero: assert property ((RD && ADDR == 5'h17) |=> RDATA[4:2] == 3'h0 && !RDATA[0])
    else $error("reserved bits not zero");
  a_read_back: assert property (s_wr_rd |=> (RDATA & 16'hFFC2) == ($past(WDATA, 2) & 16'hFFC2))
    else $error("read back wrong");
  a_rd_idle: assert property (!RD |=> RDATA == 16'h0000)
    else $error("read data not idle");
  a_lpi_clear: assert property (NET_ACTIVITY [*4] |=> !LOW_POWER_IDLE)
    else $error("low power not cleared");
endmodule // pmxc_checker
bind pmxc_top pmxc_checker i_chk (.*);

//--- tb/pmxc_top_tb.sv
// testbench for the extended control register
`timescale 1ns/100ps
module pmxc_top_tb;
  logic CLK = 0, RST = 1, WR = 0, RD = 0, NET_ACTIVITY = 0;
  logic [4:0] ADDR = 0;
  logic [15:0] WDATA = 0, RDATA;
  logic [7:0] MAC_TXD = 0, PCS_TXD;
  logic IF_GMII, IF_RGMII, IF_TBI, IF_RTBI, IO_2V5, RGMII_SKEW_EN, TBI_WRAP_TO_MAC, TBI_BIT_REVERSE, LOW_POWER_IDLE;
  int n_fail = 0, checked = 0, cyc = 0;
  pmxc_top i_dut (.*);
  always #2.5 CLK = ~CLK;
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 chk("rdata", RDATA, e);
    @(posedge CLK);
  endtask
  task give_verdict;
    $display("checks %0d fails %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      give_verdict;
    end
  end
  initial begin
    repeat (10) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    rd(5'h17, 16'h0000);
    chk("gmii", IF_GMII, 1'b1);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      wr(5'h17, 16'(i) << 12);
      chk("mode", {IF_GMII, IF_RGMII, IF_TBI, IF_RTBI}, 4'h8 >> i);
    end
    $display("test modes done");
    wr(5'h17, 16'h0FFF);
    rd(5'h17, 16'h0FE2);
    chk("rsvd", {IF_GMII, IF_TBI, TBI_WRAP_TO_MAC, IO_2V5}, 4'h8);
    chk("rev_off", TBI_BIT_REVERSE, 1'b0);
    wr(5'h1F, 16'h0000);
    rd(5'h1F, 16'h0000);
    wr(5'h17, 16'h23C2);
    MAC_TXD <= 8'h01;
    chk("ctl", {IO_2V5, RGMII_SKEW_EN, TBI_WRAP_TO_MAC, TBI_BIT_REVERSE}, 4'hF);
    repeat (2) @(posedge CLK);
    chk("txd", PCS_TXD, 8'h80);
    rd(5'h18, 16'h0006);
    ADDR <= 5'h17;
    WDATA <= 16'h1202;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 chk("b2b", RDATA, 16'h1202);
    @(posedge CLK);
    chk("rgmii", {IF_RGMII, IO_2V5}, 2'b11);
    $display("test fields done");
    wr(5'h17, 16'h0020);
    chk("lpi", LOW_POWER_IDLE, 1'b1);
    NET_ACTIVITY <= 1'b1;
    repeat (5) @(posedge CLK);
    NET_ACTIVITY <= 1'b0;
    rd(5'h17, 16'h0000);
    $display("test idle done");
    give_verdict;
  end
endmodule // pmxc_top_tb
